// ---- core/msrc_top.sv ----
//Contract
// RQ1: Reset input low holds hardware reset; high means normal operation.
// RQ2: Software reset bit 3 gives the same effect as hardware reset.
// RQ3: Outside party holds reset low at least six 20.48 MHz periods.
// RQ4: Reset returns every control register to its default value.
// RQ5: Reset halts master bit clock and receive frame sync outputs.
// RQ6: Reset terminates line driver and blocks wake-up tone detection.
// RQ7: Termination strap 1 selects network side, 0 selects line side.
// RQ8: Software selects termination side via bit 0 of register 8.
// RQ9: Host/bus strap 1 selects host control, 0 selects bus control.
// RQ10: In host mode, width strap 1 parallel port, 0 serial port.
// RQ11: Parallel port uses 8-bit data; serial uses four signals.
// RQ12: Board ties both straps low for full bus-control mode.
// RQ13: Host mode carries payload only on TDM; control via port.
// RQ14: Host mode link supports short, long, bus-style, timeslot formats.
// RQ15: Bus mode carries everything on TDM; serial port pins repurposed.
// RQ16: Line side uses frame reference pin as 8 kHz input.
// RQ17: Network host mode may drive frame reference clock, register enabled; pin toggles only with master strap high, else stays high.
// RQ18: Reset input synchronised and merged with software reset bit.
// RQ19: Termination follows strap after reset until software writes override.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
module msrc_top
   import msrc_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdata,
   input  wire logic       terminationSideSelect,
   input  wire logic       hostVsBusControlSelect,
   input  wire logic       controlPortWidthSelect,
   input  wire logic       masterSelect,
   input  wire logic       frameRefIn,
   output logic            frameRefOut,
   output logic            frameRefOe,
   input  wire logic       wakeToneIn,
   output logic            wakeToneSeen,
   output logic            lineTxTerminate,
   output logic            tdmBitClock,
   output logic            tdmBitClockOe,
   output logic            receiveFrameSync,
   output logic            receiveFrameSyncOe,
   output logic            frameRefTick,
   output logic            inReset,
   output msrc_mode_t      modeOut
);

   localparam int SRW = $clog2(MSRC_SOFTRST_CYC + 1);
   localparam int BHW = $clog2(MSRC_BITHALF_CYC);
   localparam int FBW = $clog2(MSRC_FRAME_BITS);
   localparam logic [SRW-1:0] SOFTRST_LOAD = SRW'(MSRC_SOFTRST_CYC);
   localparam logic [BHW-1:0] BITHALF_LAST = BHW'(MSRC_BITHALF_CYC - 1);
   localparam logic [FBW-1:0] FRAME_LAST   = FBW'(MSRC_FRAME_BITS - 1);

   logic           hwRunSync;
   logic [5:0]     pinSync;
   logic           strapNt;
   logic           strapHost;
   logic           strapPar;
   logic           strapMaster;
   logic           refInSync;
   logic           wakeSync;

   logic [SRW-1:0] softRstCnt_r;
   logic           intRst;
   logic           modeNt_r;
   logic           ntOverride_r;
   logic [7:0]     cfg_r;
   logic           effNt;
   logic           effHost;
   logic           masterTiming;
   logic           refOutEn;
   logic [BHW-1:0] bitDiv_r;
   logic           bitClk_r;
   logic [FBW-1:0] bitCnt_r;
   logic           refPrev_r;
   logic [7:0]     rdMux;

   // Reset input synchronised; release follows two clean edges
   msrc_sync #(.WIDTH(1)) uRstSync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .asyncIn (1'b1),
      .syncOut (hwRunSync)
   );  // RQ18

   // Straps and other pins cross into the clock domain
   msrc_sync #(.WIDTH(6)) uPinSync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .asyncIn ({terminationSideSelect, hostVsBusControlSelect,
                 controlPortWidthSelect, masterSelect, frameRefIn,
                 wakeToneIn}),
      .syncOut (pinSync)
   );

   assign strapNt     = pinSync[5];
   assign strapHost   = pinSync[4];
   assign strapPar    = pinSync[3];
   assign strapMaster = pinSync[2];
   assign refInSync   = pinSync[1];
   assign wakeSync    = pinSync[0];

   // Hardware and software reset merged into one internal reset
   assign intRst = !hwRunSync || (softRstCnt_r != '0);  // RQ1 RQ18

   // Software reset: stretched to the least hardware reset length
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         softRstCnt_r <= '0;
      end else if (regWr && regAddr == MSRC_ADR_SOFTRST &&
                   regWdata[MSRC_SOFTRST_BIT]) begin
         softRstCnt_r <= SOFTRST_LOAD;  // RQ2
      end else if (softRstCnt_r != '0) begin
         softRstCnt_r <= softRstCnt_r - SRW'(1);
      end
   end

   // Termination side register and override flag
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         modeNt_r     <= 1'b0;
         ntOverride_r <= 1'b0;
      end else if (intRst) begin
         modeNt_r     <= 1'b0;  // RQ4
         ntOverride_r <= 1'b0;  // RQ19
      end else if (regWr && regAddr == MSRC_ADR_MODE) begin
         modeNt_r     <= regWdata[MSRC_MODE_NT_BIT];  // RQ8
         ntOverride_r <= 1'b1;  // RQ19
      end
   end

   // Configuration register: link format and reference output enable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= MSRC_CFG_RST;
      end else if (intRst) begin
         cfg_r <= MSRC_CFG_RST;  // RQ4
      end else if (regWr && regAddr == MSRC_ADR_CFG) begin
         cfg_r <= regWdata & 8'h07;
      end
   end

   // Effective modes
   assign effNt        = ntOverride_r ? modeNt_r : strapNt;  // RQ7 RQ19
   assign effHost      = strapHost;  // RQ9 RQ12
   assign masterTiming = effHost && strapMaster;
   assign refOutEn     = effNt && effHost && cfg_r[MSRC_CFG_REFO_BIT];

   // Mode outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         modeOut <= '0;
      end else begin
         modeOut.networkTermination <= effNt;  // RQ7
         modeOut.hostControl        <= effHost;  // RQ9
         modeOut.parallelPort       <= effHost && strapPar;  // RQ10 RQ11
         modeOut.serialPort         <= effHost && !strapPar;  // RQ10 RQ11
         modeOut.serialPinsAlt      <= !effHost;  // RQ15
         modeOut.payloadOnlyTdm     <= effHost;  // RQ13
         modeOut.linkFormat         <= effHost ?
            msrc_fmt_t'(cfg_r[MSRC_CFG_FMT_LSB +: 2]) :
            msrc_fmt_t'(MSRC_FMT_RST);  // RQ14
      end
   end

   // Bit clock divider, halted while reset lasts
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bitDiv_r <= '0;
         bitClk_r <= 1'b0;
      end else if (intRst || !masterTiming) begin
         bitDiv_r <= '0;  // RQ5
         bitClk_r <= 1'b0;
      end else if (bitDiv_r == BITHALF_LAST) begin
         bitDiv_r <= '0;
         bitClk_r <= !bitClk_r;
      end else begin
         bitDiv_r <= bitDiv_r + BHW'(1);
      end
   end

   // Frame counter in bit clocks, advanced on each falling half
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bitCnt_r <= '0;
      end else if (intRst || !masterTiming) begin
         bitCnt_r <= '0;  // RQ5
      end else if (bitDiv_r == BITHALF_LAST && bitClk_r) begin
         bitCnt_r <= (bitCnt_r == FRAME_LAST) ? '0 : bitCnt_r + FBW'(1);
      end
   end

   // Master timing outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tdmBitClock        <= 1'b0;
         tdmBitClockOe      <= 1'b0;
         receiveFrameSync   <= 1'b0;
         receiveFrameSyncOe <= 1'b0;
      end else begin
         tdmBitClock        <= bitClk_r && !intRst;  // RQ5
         tdmBitClockOe      <= masterTiming;
         receiveFrameSync   <= (bitCnt_r == '0) && masterTiming &&
                               !intRst;  // RQ5
         receiveFrameSyncOe <= masterTiming;
      end
   end

   // Frame reference pin: input on line side, optional output on network
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         frameRefOut  <= 1'b0;
         frameRefOe   <= 1'b0;
         frameRefTick <= 1'b0;
         refPrev_r    <= 1'b0;
      end else begin
         refPrev_r    <= refInSync;
         frameRefOe   <= refOutEn && !intRst;  // RQ16 RQ17
         frameRefOut  <= refOutEn && !intRst &&
                         (bitCnt_r < FBW'(MSRC_FRAME_BITS / 2));  // RQ17
         frameRefTick <= !effNt && !intRst &&
                         refInSync && !refPrev_r;  // RQ16
      end
   end

   // Line interface behaviour during reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lineTxTerminate <= 1'b1;
         wakeToneSeen    <= 1'b0;
         inReset         <= 1'b1;
      end else begin
         lineTxTerminate <= intRst;  // RQ6
         wakeToneSeen    <= wakeSync && !intRst;  // RQ6
         inReset         <= intRst;  // RQ1
      end
   end

   // Read mux
   always_comb begin
      rdMux = 8'h00;
      case (regAddr)
         MSRC_ADR_SOFTRST: rdMux = {4'h0, (softRstCnt_r != '0), 3'h0};
         MSRC_ADR_MODE:    rdMux = {7'h00, effNt};
         MSRC_ADR_CFG:     rdMux = cfg_r;
         MSRC_ADR_STAT:    rdMux = {2'h0, masterTiming, ntOverride_r,
                                    strapMaster, strapPar, effHost, effNt};
         default:          rdMux = 8'h00;
      endcase
   end

   // Read data one cycle after the strobe
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= 8'h00;
      end else if (regRd) begin
         regRdata <= rdMux;
      end else begin
         regRdata <= 8'h00;
      end
   end

endmodule : msrc_top

// ---- core/msrc_pkg.sv ----
package msrc_pkg;

   // Register offsets (byte registers on the plain port)
   localparam logic [3:0] MSRC_ADR_SOFTRST = 4'h0;
   localparam logic [3:0] MSRC_ADR_MODE    = 4'h8;
   localparam logic [3:0] MSRC_ADR_CFG     = 4'h9;
   localparam logic [3:0] MSRC_ADR_STAT    = 4'ha;

   // Field positions
   localparam int MSRC_SOFTRST_BIT = 3;
   localparam int MSRC_MODE_NT_BIT = 0;
   localparam int MSRC_CFG_FMT_LSB = 0;
   localparam int MSRC_CFG_REFO_BIT = 2;

   // Reset values
   localparam logic [7:0] MSRC_CFG_RST  = 8'h00;
   localparam logic [1:0] MSRC_FMT_RST  = 2'h0;

   // Timing: rates in kHz, counts derived from them
   localparam int MSRC_CLK_KHZ      = 100000;
   localparam int MSRC_XTAL_KHZ     = 20480;
   localparam int MSRC_RST_PERIODS  = 6;
   localparam int MSRC_BITCLK_KHZ   = 2048;
   localparam int MSRC_FRAME_KHZ    = 8;
   // Least time: round up
   localparam int MSRC_SOFTRST_CYC  =
      (MSRC_RST_PERIODS * MSRC_CLK_KHZ + MSRC_XTAL_KHZ - 1) / MSRC_XTAL_KHZ;
   // Half bit clock period: round down
   localparam int MSRC_BITHALF_CYC  = MSRC_CLK_KHZ / (2 * MSRC_BITCLK_KHZ);
   localparam int MSRC_FRAME_BITS   = MSRC_BITCLK_KHZ / MSRC_FRAME_KHZ;

   // Data link formats in host mode
   typedef enum logic [1:0] {
      MSRC_FMT_SHORT = 2'h0,
      MSRC_FMT_LONG  = 2'h1,
      MSRC_FMT_BUSBD = 2'h2,
      MSRC_FMT_TSA   = 2'h3
   } msrc_fmt_t;

   // Effective operating mode
   typedef struct packed {
      logic      networkTermination;
      logic      hostControl;
      logic      parallelPort;
      logic      serialPort;
      logic      serialPinsAlt;
      logic      payloadOnlyTdm;
      msrc_fmt_t linkFormat;
   } msrc_mode_t;

endpackage : msrc_pkg

// ---- core/msrc_sync.sv ----
`timescale 1ns/10ps
module msrc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_r;

   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_r <= '0;
         syncOut  <= '0;
      end else begin
         stage1_r <= asyncIn;
         syncOut  <= stage1_r;
      end
   end

endmodule : msrc_sync

// ---- sim/msrc_top_monitor.sv ----
`timescale 1ns/10ps
module msrc_top_monitor
   import msrc_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regRdata,
   input wire logic       wakeToneSeen,
   input wire logic       lineTxTerminate,
   input wire logic       tdmBitClock,
   input wire logic       tdmBitClockOe,
   input wire logic       receiveFrameSync,
   input wire logic       inReset,
   input wire msrc_mode_t modeOut
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_release_seq: assert property (
      $rose(rst_n) |-> inReset ##[2:3] !inReset)
      else $error("internal reset release timing off");
   a_soft_start: assert property (
      regWr && regAddr == MSRC_ADR_SOFTRST && regWdata[MSRC_SOFTRST_BIT]
      |-> ##[1:3] inReset)
      else $error("soft reset not started");
   a_reset_term: assert property (inReset |-> lineTxTerminate)
      else $error("line not terminated in reset");
   a_reset_tone: assert property (
      inReset && $past(inReset) |-> !wakeToneSeen)
      else $error("wake tone seen in reset");
   a_reset_halt: assert property (
      inReset && $past(inReset, 2) |-> !tdmBitClock && !receiveFrameSync)
      else $error("bit clock or sync running in reset");
   a_bitclk_half: assert property (
      disable iff (!rst_n || inReset || !modeOut.hostControl
                   || !tdmBitClockOe)
      $rose(tdmBitClock) |-> ##23 tdmBitClock ##1 !tdmBitClock)
      else $error("bit clock high time wrong");
   a_read_stands: assert property (
      regRdata != 8'h00 |-> $past(regRd))
      else $error("read data outside its cycle");
   a_bus_pins: assert property (
      !inReset && !$past(inReset) && !modeOut.hostControl
      |-> modeOut.serialPinsAlt && !modeOut.serialPort
          && !modeOut.parallelPort)
      else $error("bus mode pins wrong");
   a_host_port: assert property (
      modeOut.hostControl |-> modeOut.parallelPort != modeOut.serialPort)
      else $error("host port choice wrong");
   a_host_payload: assert property (
      modeOut.hostControl |-> modeOut.payloadOnlyTdm)
      else $error("host mode tdm not payload only");
   c_soft: cover property (
      regWr && regAddr == MSRC_ADR_SOFTRST && regWdata[MSRC_SOFTRST_BIT]);
   c_bitclk: cover property ($rose(tdmBitClock));
   c_bus: cover property (!modeOut.hostControl && !inReset);
endmodule : msrc_top_monitor

// ---- sim/msrc_board.sv ----
`timescale 1ns/10ps
module msrc_board #(
   parameter int REF_CYC = 12500
) (
   input  wire logic       mclk,
   input  wire logic [1:0] modeSel,
   output logic            hostVsBusControlSelect,
   output logic            controlPortWidthSelect,
   output logic            frameRefIn
);
   int   cnt      = 0;
   logic refLevel = 1'b0;
   // Bus mode ties both straps low
   assign hostVsBusControlSelect = modeSel[1];
   assign controlPortWidthSelect = modeSel[1] & modeSel[0];
   assign frameRefIn             = refLevel;
   // Reference clock for line side
   always_ff @(posedge mclk) begin
      cnt <= (cnt == REF_CYC / 2 - 1) ? 0 : cnt + 1;
      if (cnt == REF_CYC / 2 - 1) refLevel <= ~refLevel;
   end
endmodule : msrc_board

// ---- sim/msrc_top_tb.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin nChecks++; if ((g) !== (e)) begin errTotal++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end
module msrc_top_tb
   import msrc_pkg::*;
;
   logic mclk = 0, rst_n = 0, regWr = 0, regRd = 0, wakeToneIn = 0;
   logic terminationSideSelect = 1, masterSelect = 1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWdata = 8'h00, regRdata;
   logic [1:0] modeSel = 2'h3;
   logic hostVsBusControlSelect, controlPortWidthSelect, frameRefIn;
   logic frameRefOut, frameRefOe, wakeToneSeen, lineTxTerminate, inReset;
   logic tdmBitClock, tdmBitClockOe, receiveFrameSync, receiveFrameSyncOe;
   logic frameRefTick;
   msrc_mode_t modeOut;
   int errTotal = 0, nChecks = 0, ticks;
   localparam int FRAME_CYC = MSRC_FRAME_BITS * 2 * MSRC_BITHALF_CYC;
   always #5 mclk = ~mclk;
   msrc_top dut (.*);
   msrc_board #(.REF_CYC(100)) board (.*);
   task waitc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : waitc
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : wr
   task rdc(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge mclk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 `CHK(n, e, regRdata)
   endtask : rdc
   task t_hw_reset;
      wr(4'h9, 8'h07);
      wakeToneIn <= 1'b1;
      rst_n      <= 1'b0;
      waitc(MSRC_SOFTRST_CYC);
      `CHK("inReset", 1'b1, inReset)
      `CHK("term", 1'b1, lineTxTerminate)
      `CHK("tone", 1'b0, wakeToneSeen)
      `CHK("bitclk", 1'b0, tdmBitClock)
      @(posedge mclk) rst_n <= 1;
      waitc(6);
      `CHK("inReset", 1'b0, inReset)
      `CHK("nt", terminationSideSelect, modeOut.networkTermination)
      `CHK("tone", 1'b1, wakeToneSeen)
      rdc(4'h9, 8'h00, "cfg");
      rdc(4'hf, 8'h00, "unmapped");
      wakeToneIn <= 0;
      $display("done reset");
   endtask : t_hw_reset
   task t_straps;
      for (int i = 0; i < 6; i++) begin
         modeSel <= (i < 2) ? 2'h0 : 2'(i / 2 + 1);
         terminationSideSelect <= i[0];
         waitc(6);
         `CHK("mode", {i[0], modeSel[1], modeSel == 2'h3, modeSel == 2'h2,
            !modeSel[1], modeSel[1]}, modeOut[7:2])
         `CHK("bitclkOe", modeSel[1], tdmBitClockOe)
         `CHK("syncOe", modeSel[1], receiveFrameSyncOe)
      end
      masterSelect <= 1'b0;
      waitc(6);
      `CHK("bitclkOe", 1'b0, tdmBitClockOe)
      `CHK("bitclk", 1'b0, tdmBitClock)
      masterSelect <= 1'b1;
      $display("done straps");
   endtask : t_straps
   task t_override;
      wr(4'h8, 8'h00);
      waitc(3);
      `CHK("nt", 1'b0, modeOut.networkTermination)
      terminationSideSelect <= 0;
      wr(4'h8, 8'h01);
      waitc(6);
      `CHK("nt", 1'b1, modeOut.networkTermination)
      rdc(4'h8, 8'h01, "mode");
      rdc(4'ha, 8'h3f, "stat");
      $display("done override");
   endtask : t_override
   task t_formats;
      int hiClk, hiSync, hiRef, nTick;
      for (int f = 0; f < 4; f++) begin
         wr(4'h9, 8'(f));
         waitc(3);
         `CHK("fmt", 2'(f), modeOut.linkFormat)
         rdc(4'h9, 8'(f), "cfg");
      end
      wr(4'h9, 8'h04);
      waitc(3);
      `CHK("refOe", 1'b1, frameRefOe)
      hiClk  = 0;
      hiSync = 0;
      hiRef  = 0;
      nTick  = 0;
      repeat (FRAME_CYC) @(posedge mclk) begin
         hiClk  += tdmBitClock;
         hiSync += receiveFrameSync;
         hiRef  += frameRefOut;
         nTick  += frameRefTick;
      end
      `CHK("clkHigh", FRAME_CYC / 2, hiClk)
      `CHK("syncHigh", 2 * MSRC_BITHALF_CYC, hiSync)
      `CHK("refHigh", FRAME_CYC / 2, hiRef)
      `CHK("ntTicks", 0, nTick)
      wr(4'h8, 8'h00);
      ticks = 0;
      waitc(3);
      `CHK("refOe", 1'b0, frameRefOe)
      repeat (1000) @(posedge mclk) ticks += frameRefTick;
      `CHK("ticks", 1'b1, ticks >= 9 && ticks <= 11)
      $display("done formats");
   endtask : t_formats
   task t_soft;
      wr(4'h9, 8'h07);
      wr(4'h0, 8'h08);
      waitc(2);
      `CHK("inReset", 1'b1, inReset)
      `CHK("term", 1'b1, lineTxTerminate)
      rdc(4'h0, 8'h08, "soft");
      `CHK("bitclk", 1'b0, tdmBitClock)
      waitc(40);
      `CHK("inReset", 1'b0, inReset)
      rdc(4'h9, 8'h00, "cfg");
      $display("done soft reset");
   endtask : t_soft
   task end_sim;
      $display("checks %0d mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   initial begin
      t_hw_reset();
      t_straps();
      t_override();
      t_formats();
      t_soft();
      t_hw_reset();
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      errTotal++;
      end_sim();
   end
endmodule : msrc_top_tb
bind msrc_top msrc_top_monitor mon (.*);
